// *** core/sepec_dev.sv ***
// EEPROM device end: frame capture, write-enable latch, self-timed program/erase
// Operation
// - Power-on reset clears write-enable latch
// - Enable holds until disable or reset
// - Host sends disable after each write
// - Read ignores write-enable latch state
// - Write carries 8 or 16 data bits
// - Data in sampled on serial clock rise
// - Host drops select before next clock rise
// - Mistimed select fall starts no cycle
// - Cycle self-timed regardless of serial clock
// - Write erases location before programming
// - Fill-all stores one value everywhere
// - Erase sets addressed location all ones
// - Erase starts at select falling edge
// - Erase-all sets whole array to ones
// - Busy drives low while select high
// - Input ignored while cycle in progress
// - Ready high until select falls/start bit
// - Array starts with all bits one
// - Pulse count mismatch aborts modifying instruction
// - Expected count: start, opcode, address, data
// - Start bit, opcodes and extended sub-codes
// - Org pin selects byte or word width
`timescale 1ns/1ps
module sepec_dev #(
    parameter int AW8         = 7,
    parameter int PROG_CYCLES = sepec_pkg::PROG_CYC_DEF
) (
    input  wire logic           clock,
    input  wire logic           resetn,
    sepec_if.dev                link,
    input  wire logic [AW8-1:0] mon_addr,
    output logic      [7:0]     mon_data,
    output logic                busy,
    output logic                write_en
);
    import sepec_pkg::*;

    localparam int AW16   = AW8 - 1;
    localparam int NBYTES = 2 ** AW8;
    localparam int SRW    = OPC_BITS + AW16 + DW16;
    localparam int TW     = $clog2(PROG_CYCLES + 1);
    localparam logic [TW-1:0] T_LAST  = TW'(PROG_CYCLES - 1);
    localparam logic [TW-1:0] T_HALF  = TW'(PROG_CYCLES / 2);
    localparam logic [TW-1:0] T_BYTES = TW'(NBYTES);
    localparam logic [CNT_W-1:0] SRW_C    = CNT_W'(SRW);
    localparam logic [CNT_W-1:0] LEN8_S   = CNT_W'(START_BITS + OPC_BITS + AW8);
    localparam logic [CNT_W-1:0] LEN16_S  = CNT_W'(START_BITS + OPC_BITS + AW16);
    localparam logic [CNT_W-1:0] LEN8_L   = CNT_W'(START_BITS + OPC_BITS + AW8 + DW8);
    localparam logic [CNT_W-1:0] LEN16_L  = CNT_W'(START_BITS + OPC_BITS + AW16 + DW16);

    typedef enum logic {ST_IDLE, ST_PROG} sepec_dst_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: counts pulses from the start bit and shifts in every bit after it
    logic                 started_q;
    logic [CNT_W-1:0]     cnt_q;
    logic [SRW-1:0]       sr_q;

    // Select low clears the frame at once, so a stopped clock cannot leave it armed
    always_ff @(posedge link.sclk or negedge link.cs) begin
        if (!link.cs) begin
            started_q <= 1'b0;
        end else if (link.din) begin
            started_q <= 1'b1;
        end
    end

    // Held while select is low so the core domain reads settled values
    always_ff @(posedge link.sclk) begin
        if (link.cs) begin
            if (!started_q) begin
                cnt_q <= link.din ? CNT_ONE : '0;
                sr_q  <= '0;
            end else begin
                sr_q <= {sr_q[SRW-2:0], link.din};
                if (cnt_q != CNT_MAX) begin
                    cnt_q <= cnt_q + CNT_ONE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers into the core clock
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic st_m;
    logic st_s;
    logic org_m;
    logic org_s;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cs_m  <= 1'b0;
            cs_s  <= 1'b0;
            cs_d  <= 1'b0;
            st_m  <= 1'b0;
            st_s  <= 1'b0;
            org_m <= 1'b0;
            org_s <= 1'b0;
        end else begin
            cs_m  <= link.cs;
            cs_s  <= cs_m;
            cs_d  <= cs_s;
            st_m  <= started_q;
            st_s  <= st_m;
            org_m <= link.org;
            org_s <= org_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame decode at the falling edge of select
    sepec_dst_e           st_q;
    sepec_dst_e           st_d;
    logic                 seen_q;
    logic                 wen_q;
    logic                 ready_q;
    logic [TW-1:0]        tmr_q;
    logic [TW-1:0]        tmr_d;
    logic [AW8-1:0]       addr_q;
    logic [15:0]          data_q;
    logic                 word_q;
    logic                 all_q;
    logic                 erase_q;
    logic                 dout_q;
    logic                 oe_n_q;

    wire                  frame_end = cs_d & ~cs_s;
    wire [CNT_W-1:0]      nbits     = cnt_q - CNT_ONE;
    wire [CNT_W-1:0]      shamt     = SRW_C - nbits;
    wire [SRW-1:0]        algn      = sr_q << shamt;
    wire [1:0]            opc       = algn[SRW-1 -: 2];
    wire [1:0]            sub       = algn[SRW-3 -: 2];
    wire [AW8-1:0]        adr8      = algn[SRW-3 -: AW8];
    wire [AW16-1:0]       adr16     = algn[SRW-3 -: AW16];
    wire [7:0]            dat8      = algn[SRW-3-AW8 -: DW8];
    wire [15:0]           dat16     = algn[SRW-3-AW16 -: DW16];
    wire [CNT_W-1:0]      len_s     = org_s ? LEN16_S : LEN8_S;
    wire [CNT_W-1:0]      len_l     = org_s ? LEN16_L : LEN8_L;
    wire                  ext       = (opc == OPC_EXT);
    wire                  ok_s      = (cnt_q == len_s);
    wire                  ok_l      = (cnt_q == len_l);
    wire                  is_wr     = (opc == OPC_WRITE) & ok_l;
    wire                  is_er     = (opc == OPC_ERASE) & ok_s;
    wire                  is_fill   = ext & (sub == SUB_FILL_ALL) & ok_l;
    wire                  is_erase_all_instr   = ext & (sub == SUB_ERASE_ALL) & ok_s;
    wire                  is_en     = ext & (sub == SUB_WRITE_ENABLE) & ok_s;
    wire                  is_dis    = ext & (sub == SUB_WRITE_DISABLE) & ok_s;
    // Frames that end while a cycle runs are dropped whole
    wire                  accept    = frame_end & seen_q & (st_q == ST_IDLE);
    // Read frames take no action here whatever the latch holds
    wire                  modify    = is_wr | is_er | is_fill | is_erase_all_instr;
    wire                  start_mod = accept & wen_q & modify;
    wire                  start_dec = cs_s & st_s;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            seen_q <= 1'b0;
        end else if (frame_end) begin
            seen_q <= 1'b0;
        end else if (start_dec) begin
            seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wen_q <= 1'b0;
        end else if (accept & is_en) begin
            wen_q <= 1'b1;
        end else if (accept & is_dis) begin
            wen_q <= 1'b0;
        end
    end

    // Word mode keeps the low data byte at the even byte of the pair
    always_ff @(posedge clock) begin
        if (!resetn) begin
            addr_q  <= '0;
            data_q  <= '0;
            word_q  <= 1'b0;
            all_q   <= 1'b0;
            erase_q <= 1'b0;
        end else if (start_mod) begin
            addr_q  <= org_s ? {adr16, 1'b0} : adr8;
            data_q  <= org_s ? dat16 : {8'h00, dat8};
            word_q  <= org_s;
            all_q   <= is_fill | is_erase_all_instr;
            erase_q <= is_er | is_erase_all_instr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-timed cycle on the core clock: erase sweep, then program sweep
    always_comb begin
        st_d  = st_q;
        tmr_d = tmr_q;
        case (st_q)
            ST_IDLE: begin
                tmr_d = '0;
                if (start_mod) begin
                    st_d = ST_PROG;
                end
            end
            ST_PROG: begin
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == T_LAST) begin
                    st_d  = ST_IDLE;
                    tmr_d = '0;
                end
            end
            default: begin
                st_d  = ST_IDLE;
                tmr_d = '0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q  <= ST_IDLE;
            tmr_q <= '0;
        end else begin
            st_q  <= st_d;
            tmr_q <= tmr_d;
        end
    end

    wire                  in_erase = (tmr_q < T_BYTES);
    wire                  in_prog  = (tmr_q >= T_HALF) & (tmr_q < T_HALF + T_BYTES);
    wire [TW-1:0]         prog_ix  = tmr_q - T_HALF;
    wire [AW8-1:0]        idx      = in_erase ? tmr_q[AW8-1:0] : prog_ix[AW8-1:0];
    wire                  hit_word = (idx[AW8-1:1] == addr_q[AW8-1:1]);
    wire                  hit      = all_q | (word_q ? hit_word : (idx == addr_q));
    wire [7:0]            prog_val = (word_q & idx[0]) ? data_q[15:8] : data_q[7:0];
    logic [7:0] mem_q [NBYTES] = '{default: ERASED_BYTE};

    // Every write first sweeps its bytes to ones
    wire                  mem_we   = (st_q == ST_PROG) & hit & (in_erase | (in_prog & ~erase_q));
    // Programming only clears bits, so a skipped erase would corrupt the stored value
    wire [7:0]            mem_val  = in_erase ? ERASED_BYTE : (mem_q[idx] & prog_val);

    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem_q[idx] <= mem_val;
        end
        mon_data <= mem_q[mon_addr];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ready/busy on data out, only while select is high
    wire                  cyc_done = (st_q == ST_PROG) & (tmr_q == T_LAST);

    // Completion wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ready_q <= 1'b0;
        end else if (cyc_done) begin
            ready_q <= 1'b1;
        end else if (frame_end | start_dec) begin
            ready_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            dout_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else begin
            dout_q <= (st_q != ST_PROG);
            oe_n_q <= ~(cs_s & ((st_q == ST_PROG) | ready_q));
        end
    end

    assign link.dout_o    = dout_q;
    assign link.dout_oe_n = oe_n_q;
    assign busy           = (st_q == ST_PROG);
    assign write_en       = wen_q;
endmodule

// *** core/sepec_pkg.sv ***
// Shared constants and types for the serial EEPROM program/erase link
package sepec_pkg;
    localparam int START_BITS = 1;
    localparam int OPC_BITS   = 2;
    localparam int DW8        = 8;
    localparam int DW16       = 16;

    localparam logic [1:0] OPC_READ  = 2'h2;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] OPC_EXT   = 2'h0;

    // Sub-codes carried in the two top address bits of the extended opcode
    localparam logic [1:0] SUB_WRITE_ENABLE  = 2'h3;
    localparam logic [1:0] SUB_WRITE_DISABLE = 2'h0;
    localparam logic [1:0] SUB_ERASE_ALL     = 2'h2;
    localparam logic [1:0] SUB_FILL_ALL      = 2'h1;

    localparam logic [7:0] ERASED_BYTE = 8'hff;

    localparam int         CNT_W   = 6;
    localparam logic [5:0] CNT_ONE = 6'h01;
    localparam logic [5:0] CNT_MAX = 6'h3f;

    localparam int CLK_PERIOD_NS               = 25;
    localparam int DESELECT_TO_STATUS_TIME_NS  = 250;
    localparam int STATUS_CYC = (DESELECT_TO_STATUS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC   = 2;
    localparam int GAP_CYC    = 8;
    localparam int PROG_TIME_NS = 5000000;
    localparam int PROG_CYC_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        OP_WRITE,
        OP_ERASE,
        OP_FILL_ALL,
        OP_ERASE_ALL,
        OP_WRITE_ENABLE,
        OP_WRITE_DISABLE
    } sepec_op_e;
endpackage

// *** core/sepec_if.sv ***
// Three-wire serial link between host and EEPROM device
`timescale 1ns/1ps
interface sepec_if;
    logic sclk;
    logic cs;
    logic din;
    logic org;
    logic dout_o;
    logic dout_oe_n;
    logic dout;

    // Released data-out line reads high, as through a pull-up
    assign dout = dout_oe_n ? 1'b1 : dout_o;

    modport host (
        output sclk,
        output cs,
        output din,
        output org,
        input  dout
    );
    modport dev (
        input  sclk,
        input  cs,
        input  din,
        input  org,
        output dout_o,
        output dout_oe_n
    );
endinterface

// *** core/sepec_host.sv ***
// Host end: builds instruction frames, drives serial clock, polls ready/busy
`timescale 1ns/1ps
module sepec_host #(
    parameter int AW8          = 7,
    parameter int HALF_DIV     = 2,
    parameter bit AUTO_DISABLE = 1'b1
) (
    input  wire logic                 clock,
    input  wire logic                 resetn,
    sepec_if.host                     link,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire sepec_pkg::sepec_op_e cmd_op,
    input  wire logic [AW8-1:0]       cmd_addr,
    input  wire logic [15:0]          cmd_data,
    input  wire logic                 org_sel,
    output logic                      done
);
    import sepec_pkg::*;

    localparam int AW16 = AW8 - 1;
    localparam int FW   = START_BITS + OPC_BITS + AW16 + DW16;
    localparam int DVW  = $clog2(HALF_DIV + 1);
    localparam logic [DVW-1:0]   DV_LAST = DVW'(HALF_DIV - 1);
    localparam logic [7:0]       GAP_END = 8'(GAP_CYC - 1);
    localparam logic [7:0]       WT_END  = 8'(STATUS_CYC + SYNC_CYC - 1);
    localparam logic [CNT_W-1:0] LEFT_1  = CNT_ONE;

    typedef enum logic [2:0] {H_IDLE, H_SEND, H_GAP, H_WAIT, H_POLL} sepec_hst_e;

    function automatic logic is_mod(input sepec_op_e op);
        return (op == OP_WRITE) | (op == OP_ERASE) | (op == OP_FILL_ALL) | (op == OP_ERASE_ALL);
    endfunction

    function automatic logic [CNT_W-1:0] frame_len(input sepec_op_e op, input logic wide);
        int n;
        n = START_BITS + OPC_BITS + (wide ? AW16 : AW8);
        if ((op == OP_WRITE) | (op == OP_FILL_ALL)) begin
            n = n + (wide ? DW16 : DW8);
        end
        return CNT_W'(n);
    endfunction

    // Frame left-aligned in FW bits, start bit first
    function automatic logic [FW-1:0] frame_bits(input sepec_op_e op, input logic [AW8-1:0] a,
                                                 input logic [15:0] d, input logic wide);
        logic [1:0]     opc;
        logic [1:0]     sub;
        logic [AW8-1:0] af;
        logic [FW-1:0]  v;
        int             aw;
        int             dw;
        aw  = wide ? AW16 : AW8;
        dw  = is_mod(op) & ((op == OP_WRITE) | (op == OP_FILL_ALL)) ? (wide ? DW16 : DW8) : 0;
        opc = OPC_EXT;
        sub = SUB_WRITE_DISABLE;
        case (op)
            OP_WRITE:        opc = OPC_WRITE;
            OP_ERASE:        opc = OPC_ERASE;
            OP_FILL_ALL:     sub = SUB_FILL_ALL;
            OP_ERASE_ALL:    sub = SUB_ERASE_ALL;
            OP_WRITE_ENABLE: sub = SUB_WRITE_ENABLE;
            default:         sub = SUB_WRITE_DISABLE;
        endcase
        af = wide ? {1'b0, a[AW16-1:0]} : a;
        if (opc == OPC_EXT) begin
            af = {sub, {(AW8-2){1'b0}}} >> (AW8 - aw);
        end
        v = FW'({1'b1, opc});
        v = (v << aw) | FW'(af);
        v = (v << dw) | ((dw == 0) ? '0 : (wide ? FW'(d) : FW'(d[7:0])));
        return v << (FW - (START_BITS + OPC_BITS + aw + dw));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    sepec_hst_e       st_q;
    logic [DVW-1:0]   div_q;
    logic             sclk_q;
    logic             cs_q;
    logic             din_q;
    logic             org_q;
    logic [FW-1:0]    sh_q;
    logic [CNT_W-1:0] left_q;
    logic [7:0]       cnt_q;
    logic             mod_q;
    logic             lock_q;
    logic             done_q;
    logic             dout_m;
    logic             dout_s;

    wire              tick     = (div_q == DV_LAST);
    wire              load     = cmd_valid & cmd_ready;
    wire [FW-1:0]     cmd_fb   = frame_bits(cmd_op, cmd_addr, cmd_data, org_sel);
    wire [FW-1:0]     dis_fb   = frame_bits(OP_WRITE_DISABLE, '0, '0, org_q);

    assign cmd_ready = (st_q == H_IDLE);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            dout_m <= 1'b0;
            dout_s <= 1'b0;
            div_q  <= '0;
        end else begin
            dout_m <= link.dout;
            dout_s <= dout_m;
            div_q  <= ((st_q != H_SEND) | tick) ? '0 : div_q + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q   <= H_IDLE;
            sclk_q <= 1'b0;
            cs_q   <= 1'b0;
            din_q  <= 1'b0;
            org_q  <= 1'b0;
            sh_q   <= '0;
            left_q <= '0;
            cnt_q  <= '0;
            mod_q  <= 1'b0;
            lock_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                H_IDLE: begin
                    if (load) begin
                        sh_q   <= cmd_fb;
                        din_q  <= cmd_fb[FW-1];
                        left_q <= frame_len(cmd_op, org_sel);
                        org_q  <= org_sel;
                        mod_q  <= is_mod(cmd_op);
                        cs_q   <= 1'b1;
                        st_q   <= H_SEND;
                    end
                end
                H_SEND: begin
                    if (tick) begin
                        sclk_q <= ~sclk_q;
                        // Next bit changes on the falling edge, ahead of the rise
                        if (sclk_q) begin
                            if (left_q == LEFT_1) begin
                                cs_q  <= 1'b0;
                                din_q <= 1'b0;
                                cnt_q <= '0;
                                st_q  <= H_GAP;
                            end else begin
                                left_q <= left_q - CNT_ONE;
                                sh_q   <= sh_q << 1;
                                din_q  <= sh_q[FW-2];
                            end
                        end
                    end
                end
                H_GAP: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == GAP_END) begin
                        cnt_q <= '0;
                        if (mod_q) begin
                            mod_q <= 1'b0;
                            cs_q  <= 1'b1;
                            st_q  <= H_WAIT;
                        end else if (lock_q) begin
                            lock_q <= 1'b0;
                            sh_q   <= dis_fb;
                            din_q  <= dis_fb[FW-1];
                            left_q <= frame_len(OP_WRITE_DISABLE, org_q);
                            cs_q   <= 1'b1;
                            st_q   <= H_SEND;
                        end else begin
                            done_q <= 1'b1;
                            st_q   <= H_IDLE;
                        end
                    end
                end
                H_WAIT: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == WT_END) begin
                        st_q <= H_POLL;
                    end
                end
                H_POLL: begin
                    if (dout_s) begin
                        cs_q   <= 1'b0;
                        lock_q <= AUTO_DISABLE;
                        cnt_q  <= '0;
                        st_q   <= H_GAP;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs   = cs_q;
    assign link.din  = din_q;
    assign link.org  = org_q;
    assign done      = done_q;
endmodule

// *** testbench/sepec_monitor.sv ***
// Link checker for the host and device ends
`timescale 1ns/1ps
module sepec_monitor #(
    parameter int PROG_CYCLES = 300
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs,
    input wire logic din,
    input wire logic dout_oe_n,
    input wire logic dout,
    input wire logic busy,
    input wire logic write_en
);
    logic [31:0] bcnt_q;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    always_ff @(posedge clock) begin
        bcnt_q <= (busy && resetn) ? bcnt_q + 32'h1 : 32'h0;
    end
    ////////////////////////////////////////////////////////////////
    // Four cycles gives the status path time to settle after select
    sequence s_busy_sel;
        (busy && cs)[*4];
    endsequence
    sequence s_idle_sel;
        !busy[*4] ##0 cs;
    endsequence
    a_busy_drives_low: assert property (s_busy_sel |-> !dout)
        else $error("status not busy while cycle runs");
    a_ready_drives_high: assert property (s_idle_sel |-> dout)
        else $error("status not ready when idle");
    a_busy_needs_latch: assert property ($rose(busy) |-> write_en)
        else $error("cycle started with latch clear");
    a_start_after_deselect: assert property ($rose(busy) |-> !$past(cs) &&
        ($past(cs, 3) || $past(cs, 4) || $past(cs, 5)))
        else $error("cycle not started by select fall");
    a_cycle_self_timed: assert property ($fell(busy) |-> bcnt_q == PROG_CYCLES)
        else $error("cycle length wrong");
    a_release_on_deselect: assert property ($fell(cs) |-> ##[1:4] dout_oe_n)
        else $error("data out not released");
    a_sclk_idle_low: assert property (!cs |-> !sclk)
        else $error("serial clock outside frame");
    a_din_stable_rise: assert property ($rose(sclk) |-> $stable(din))
        else $error("data in moved at clock rise");
    a_latch_by_frame: assert property ($changed(write_en) |-> !cs)
        else $error("latch changed inside frame");
endmodule

// *** testbench/tb.sv ***
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
module tb;
    import sepec_pkg::*;
    logic        clock, resetn, cmd_valid, org_sel, busy_seen;
    logic        cmd_ready, done, busy, write_en;
    sepec_op_e   cmd_op;
    logic [6:0]  cmd_addr, mon_addr;
    logic [15:0] cmd_data;
    logic [7:0]  mon_data;
    int          fails, check_count, cycles;
    sepec_if sepec_if_inst ();
    sepec_host sepec_host_inst (.clock(clock), .resetn(resetn), .link(sepec_if_inst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .org_sel(org_sel), .done(done));
    // Short cycle keeps the run small; it still covers a full array sweep
    sepec_dev #(.PROG_CYCLES(300)) sepec_dev_inst (.clock(clock), .resetn(resetn),
        .link(sepec_if_inst), .mon_addr(mon_addr), .mon_data(mon_data),
        .busy(busy), .write_en(write_en));
    sepec_monitor #(.PROG_CYCLES(300)) sepec_monitor_inst (.clock(clock),
        .resetn(resetn), .sclk(sepec_if_inst.sclk), .cs(sepec_if_inst.cs),
        .din(sepec_if_inst.din), .dout_oe_n(sepec_if_inst.dout_oe_n),
        .dout(sepec_if_inst.dout), .busy(busy), .write_en(write_en));
    ////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (busy === 1'b1) busy_seen = 1'b1;
        cycles = cycles + 1;
        if (cycles == 40000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic run(input sepec_op_e op, input logic [6:0] a, input logic [15:0] d,
                       input logic org);
        int n;
        @(negedge clock);
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        org_sel = org;
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(negedge clock);
            n++;
        end
        check("done", {15'h0, done}, 16'h1);
    endtask
    task automatic peek(input logic [6:0] a, input logic [7:0] exp);
        @(negedge clock);
        mon_addr = a;
        @(negedge clock);
        @(negedge clock);
        check("array", {8'h0, mon_data}, {8'h0, exp});
    endtask
    task automatic mod(input sepec_op_e op, input logic [6:0] a, input logic [15:0] d,
                       input logic org);
        run(OP_WRITE_ENABLE, 7'h00, 16'h0000, org);
        check("latch", {15'h0, write_en}, 16'h1);
        busy_seen = 1'b0;
        run(op, a, d, org);
        check("busy_seen", {15'h0, busy_seen}, 16'h1);
        check("latch", {15'h0, write_en}, 16'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_locked;
        check("latch", {15'h0, write_en}, 16'h0);
        peek(7'h7f, ERASED_BYTE);
        busy_seen = 1'b0;
        run(OP_WRITE, 7'h05, 16'h003c, 1'b0);
        check("busy_seen", {15'h0, busy_seen}, 16'h0);
        peek(7'h05, ERASED_BYTE);
        $display("test locked finished");
    endtask
    task automatic t_write;
        mod(OP_WRITE, 7'h05, 16'h003c, 1'b0);
        peek(7'h05, 8'h3c);
        // Overlapping bits would read 00 if the pre-erase were skipped
        mod(OP_WRITE, 7'h05, 16'h00c3, 1'b0);
        peek(7'h05, 8'hc3);
        mod(OP_WRITE, 7'h03, 16'h1234, 1'b1);
        peek(7'h06, 8'h34);
        peek(7'h07, 8'h12);
        $display("test write finished");
    endtask
    task automatic t_erase;
        mod(OP_ERASE, 7'h05, 16'h0000, 1'b0);
        peek(7'h05, ERASED_BYTE);
        peek(7'h06, 8'h34);
        mod(OP_ERASE, 7'h03, 16'h0000, 1'b1);
        peek(7'h06, ERASED_BYTE);
        peek(7'h07, ERASED_BYTE);
        mod(OP_FILL_ALL, 7'h00, 16'h005a, 1'b0);
        peek(7'h00, 8'h5a);
        peek(7'h7f, 8'h5a);
        mod(OP_FILL_ALL, 7'h00, 16'ha55a, 1'b1);
        peek(7'h7e, 8'h5a);
        peek(7'h7f, 8'ha5);
        mod(OP_ERASE_ALL, 7'h00, 16'h0000, 1'b0);
        peek(7'h00, ERASED_BYTE);
        peek(7'h7f, ERASED_BYTE);
        $display("test erase finished");
    endtask
    // Reset after an enable run must drop a set latch
    task automatic t_reset;
        run(OP_WRITE_ENABLE, 7'h00, 16'h0000, 1'b0);
        check("latch", {15'h0, write_en}, 16'h1);
        @(negedge clock);
        resetn = 1'b0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        check("latch", {15'h0, write_en}, 16'h0);
        $display("test reset finished");
    endtask
    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_WRITE;
        cmd_addr = 7'h00;
        cmd_data = 16'h0000;
        org_sel = 1'b0;
        mon_addr = 7'h00;
        busy_seen = 1'b0;
        fails = 0;
        check_count = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        t_locked();
        t_reset();
        t_write();
        t_erase();
        tally_and_finish();
    end
endmodule
